// ===== ssa_adc_timing.sv
// single slope converter timing, ramp control and result capture
// Operation
// - four channels convert together, sharing one count timer
// - aux channel input chosen 4-to-1 by two select bits; code 3 is reference
// - time from ramp start to trip counted in 12 bits and stored
// - each sync pulse resets the ramp and restarts the timer
// - rate bit 7 clear: count every second clock; set: every clock
// - three main and four aux comparators; a main or selected aux trip latches the timer into that channel result
// - count saturates at 4095, else limited by the sync spacing
// - window is the sync period, full or half PWM period
// - 3-bit ramp current trim, resets to zero
// - channel with no trip in the window reports zero
`timescale 1ns/1ps
`default_nettype none
module ssa_adc_timing
  import ssa_pkg::*;
#(
  parameter int CNT_W = SSA_CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm sync and analog side
  input wire logic pwm_cycle_sync_pulse,
  input wire logic [2:0] comp_trip,
  input wire logic [3:0] comp_aux_in,
  output logic ramp_discharge,
  output logic [1:0] aux_mux_sel,
  output logic [SSA_TRIM_W-1:0] ramp_current_trim
);
  // ==========================================================
  // input synchronisers
  // ==========================================================
  // three main comparators plus the four aux comparators
  localparam int NPIN = 2 * SSA_NCH - 1;

  logic sync_m_q, sync_s_q, sync_prev_q;
  logic [NPIN-1:0] pin_raw, pin_s;
  logic [SSA_NCH-2:0] cmp_s;
  logic [SSA_NCH-1:0] caux_s;

  // the sync pulse comes from the pwm timer, not from this logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_q <= 1'b0;
    end else begin
      sync_m_q <= pwm_cycle_sync_pulse;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s_q <= 1'b0;
    end else begin
      sync_s_q <= sync_m_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_s_q;
    end
  end

  // ==========================================================
  // comparator synchronisers
  // ==========================================================
  // comparators flip when the ramp crosses, at no fixed clock phase
  assign pin_raw = {comp_aux_in, comp_trip};

  genvar b;
  generate
    for (b = 0; b < NPIN; b++) begin : g_pin_sync
      logic m_q;
      logic s_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          m_q <= 1'b0;
          s_q <= 1'b0;
        end else begin
          m_q <= pin_raw[b];
          s_q <= m_q;
        end
      end
      assign pin_s[b] = s_q;
    end
  endgenerate

  assign cmp_s = pin_s[SSA_NCH-2:0];
  assign caux_s = pin_s[NPIN-1:SSA_NCH-1];

  // ==========================================================
  // registers
  // ==========================================================
  logic [SSA_MODE_W-1:0] mode_control_reg_q;
  logic [SSA_TRIM_W-1:0] trim_q;
  logic apb_req, apb_wr, apb_rd;
  logic hit_mode, hit_trim, hit_stat, hit_res, hit_any;
  logic wr_mode, wr_trim;

  // apb_req stands from the setup cycle until the answer goes out
  assign apb_req = psel && !pready;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign hit_mode = (paddr == SSA_OFF_MODE);
  assign hit_trim = (paddr == SSA_OFF_TRIM);
  assign hit_stat = (paddr == SSA_OFF_STATUS);
  assign hit_res = (paddr == SSA_OFF_RES1) || (paddr == SSA_OFF_RES2) ||
                   (paddr == SSA_OFF_RES3) || (paddr == SSA_OFF_RESAUX);
  assign hit_any = hit_mode || hit_trim || hit_stat || hit_res;
  // an unmapped write lands nowhere
  assign wr_mode = apb_wr && hit_mode;
  assign wr_trim = apb_wr && hit_trim;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control_reg_q <= SSA_MODE_RST;
    end else if (wr_mode) begin
      mode_control_reg_q <= pwdata[SSA_MODE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= SSA_TRIM_RST;
    end else if (wr_trim) begin
      trim_q <= pwdata[SSA_TRIM_W-1:0];
    end
  end

  // ==========================================================
  // mode field decode
  // ==========================================================
  logic aux_select_hi, aux_select_lo, count_rate_select;
  assign aux_select_hi = mode_control_reg_q[SSA_MUX_HI_BIT];
  assign aux_select_lo = mode_control_reg_q[SSA_MUX_LO_BIT];
  assign count_rate_select = mode_control_reg_q[SSA_RATE_BIT];

  // ==========================================================
  // conversion sequencing
  // ==========================================================
  ssa_state_t state_q, state_d;
  logic [CNT_W-1:0] timer_q, timer_d;
  logic half_q, half_d;
  logic [SSA_NCH-1:0] done_q, done_d, trip_now;
  logic sync_rise, sync_fall, tick, sat, ramping;
  ssa_capture_t cap;

  assign sync_rise = sync_s_q && !sync_prev_q;
  assign sync_fall = !sync_s_q && sync_prev_q;
  assign ramping = (state_q == SSA_RAMP);
  // the half rate tick mirrors the slower input clock
  assign tick = count_rate_select || half_q;
  assign half_d = sync_rise ? 1'b0 : !half_q;
  // hold at full scale rather than wrap to a small count
  assign sat = (timer_q == CNT_W'(SSA_CNT_MAX));
  // one shared timer; the aux comparator follows the selector
  assign trip_now = {caux_s[aux_mux_sel], cmp_s};

  // timer value and trip levels travel together to the capture logic
  assign cap.count = SSA_CNT_W'(timer_q);
  assign cap.trip = trip_now;

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    done_d = done_q;
    if (sync_rise) begin
      // every sync starts a new window
      state_d = SSA_RESET_RAMP;
      timer_d = '0;
      done_d = '0;
    end else if (state_q == SSA_RESET_RAMP) begin
      if (sync_fall) begin
        state_d = SSA_RAMP;
      end
    end else begin
      if (tick && !sat) begin
        timer_d = CNT_W'(timer_q + 1'b1);
      end
      done_d = done_q | cap.trip;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SSA_RESET_RAMP;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= '0;
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_d;
    end
  end

  // ==========================================================
  // result capture
  // ==========================================================
  logic [SSA_NCH-1:0] first_trip, no_conv, wr_en;
  logic [CNT_W-1:0] wr_data [SSA_NCH];
  logic [CNT_W-1:0] res_rd_data;

  // latch the count on first trip; zero for channels never tripped
  genvar c;
  generate
    for (c = 0; c < SSA_NCH; c++) begin : g_ch
      assign first_trip[c] = cap.trip[c] && !done_q[c] && !sync_rise;
      assign no_conv[c] = sync_rise && !done_q[c];
      assign wr_en[c] = ramping && (first_trip[c] || no_conv[c]);
      assign wr_data[c] = sync_rise ? CNT_W'(SSA_NO_CONV) :
                                      CNT_W'(cap.count);
    end
  endgenerate

  // a word changes only on its own channel's write enable
  ssa_result_mem #(
    .NCH(SSA_NCH),
    .W(CNT_W)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_idx(paddr[3:2]),
    .rd_data(res_rd_data)
  );

  // ==========================================================
  // analog side outputs
  // ==========================================================
  logic discharge_d;
  logic [1:0] aux_sel_d;

  assign discharge_d = (state_d == SSA_RESET_RAMP);
  assign aux_sel_d = {aux_select_hi, aux_select_lo};

  // reset holds the ramp at zero so nothing counts before software is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_discharge <= 1'b1;
    end else begin
      ramp_discharge <= discharge_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_mux_sel <= SSA_SEL_AUX0;
    end else begin
      aux_mux_sel <= aux_sel_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_current_trim <= SSA_TRIM_RST;
    end else begin
      ramp_current_trim <= trim_q;
    end
  end

  // ==========================================================
  // apb answer
  // ==========================================================
  // result reads take two cycles so the word comes from the memory register
  logic rd_wait_q, hold_rd, ans_now;
  logic [31:0] stat_word, rd_word;

  // writes and plain reads answer at once: the data is already in hand
  assign hold_rd = apb_req && !pwrite && hit_res && !rd_wait_q;
  assign ans_now = apb_req && !hold_rd;
  // status: ramping flag in bit 0, per-channel trip flags in bits 7:4
  assign stat_word = 32'({done_q, 3'h0, state_q});
  assign rd_word = hit_mode ? 32'(mode_control_reg_q) :
                   hit_trim ? 32'(trim_q) :
                   hit_stat ? stat_word :
                   hit_res ? 32'(res_rd_data) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= hold_rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= ans_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= ans_now && !hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_req && apb_rd) begin
      prdata <= rd_word;
    end
  end
endmodule // ssa_adc_timing
`default_nettype wire

// ===== ssa_adc_timing_chk.sv
// assertion checker for the converter timing block
`timescale 1ns/1ps
`default_nettype none
module ssa_adc_timing_chk
  import ssa_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // converter side
  input wire logic pwm_cycle_sync_pulse,
  input wire logic ramp_discharge,
  input wire logic [1:0] aux_mux_sel,
  input wire logic [2:0] ramp_current_trim
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  wire logic wm = acc && pwrite && paddr == SSA_OFF_MODE;
  wire logic wt = acc && pwrite && paddr == SSA_OFF_TRIM;
  // setup cycle of a result read
  wire logic rr = psel && !penable && !pwrite && paddr[4];
  a_disch_sync: assert property (
    pwm_cycle_sync_pulse [*5] |-> ramp_discharge) else $error("ramp held");
  a_ramp_runs: assert property (
    $fell(pwm_cycle_sync_pulse) ##1 !pwm_cycle_sync_pulse [*4]
    |-> !ramp_discharge) else $error("ramp stuck");
  a_sel_write: assert property (
    wm |-> ##2 aux_mux_sel == $past(pwdata[1:0], 2)) else $error("select");
  a_trim_write: assert property (
    wt |-> ##2 ramp_current_trim == $past(pwdata[2:0], 2))
    else $error("trim");
  a_trim_hold: assert property (
    !wt && !$past(wt) |=> $stable(ramp_current_trim))
    else $error("trim moved");
  a_trim_read: assert property (
    acc && !pwrite && paddr == SSA_OFF_TRIM
    |-> prdata[2:0] == ramp_current_trim) else $error("trim read");
  a_res_latency: assert property (
    rr |-> ##1 !pready ##1 pready) else $error("result latency");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("ready width");
endmodule // ssa_adc_timing_chk
bind ssa_adc_timing ssa_adc_timing_chk i_chk (.*);
`default_nettype wire

// ===== ssa_adc_timing_tb_top.sv
// testbench for the converter timing block
`timescale 1ns/1ps
`default_nettype none
module ssa_adc_timing_tb_top
  import ssa_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pwm_cycle_sync_pulse = 1'b0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, r1;
  logic ramp_discharge;
  logic [1:0] aux_mux_sel;
  logic [2:0] ramp_current_trim, comp_trip;
  logic [3:0] comp_aux_in;
  logic [15:0] thr [7] = '{16'd100, 16'd140, 16'd250, 16'd110, 16'd120,
    16'd160, 16'd130};
  int err_count = 0;
  int compares = 0;
  ssa_adc_timing i_ssa_adc_timing (.*);
  ssa_ramp_model i_ssa_ramp_model (.*);
  always #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ramp runs for len clocks, then is held again for reading
  task automatic conv(input int len);
    pwm_cycle_sync_pulse <= 1'b1;
    repeat (8) @(posedge pclk);
    pwm_cycle_sync_pulse <= 1'b0;
    repeat (len) @(posedge pclk);
    pwm_cycle_sync_pulse <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, SSA_OFF_TRIM, 32'h0);
      chk(r, i > 0 ? i - 1 : 0);
      xfer(1'b1, SSA_OFF_TRIM, i);
    end
    xfer(1'b0, 8'h0c, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    for (int s = 0; s < 5; s++) begin
      thr[2] <= s[0] ? 16'd250 : 16'd9999;
      xfer(1'b1, SSA_OFF_MODE, s < 4 ? 32'h80 | s : 32'h2);
      repeat (2) @(posedge pclk);
      chk(aux_mux_sel, s < 4 ? s : 2);
      conv(300);
      xfer(1'b0, SSA_OFF_RES1, 32'h0);
      r1 = r;
      xfer(1'b0, SSA_OFF_RES2, 32'h0);
      chk(r - r1, s < 4 ? 32'd40 : 32'd20);
      xfer(1'b0, SSA_OFF_RESAUX, 32'h0);
      chk(r - r1, s < 4 ? thr[s+3] - 16'd100 : 32'd30);
      xfer(1'b0, SSA_OFF_RES3, 32'h0);
      chk(s[0] ? r - r1 : r, s[0] ? 32'd150 : 32'h0);
      xfer(1'b0, SSA_OFF_RES1, 32'h0);
      chk(r, r1);
    end
    thr[0] <= 16'd4300;
    xfer(1'b1, SSA_OFF_MODE, 32'h80);
    conv(4500);
    xfer(1'b0, SSA_OFF_RES1, 32'h0);
    chk(r, 32'hfff);
    end_of_test();
  end
endmodule // ssa_adc_timing_tb_top
`default_nettype wire

// ===== ssa_pkg.sv
// package for the single slope converter timing block
package ssa_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] SSA_OFF_MODE = 8'h00;
  localparam logic [7:0] SSA_OFF_TRIM = 8'h04;
  localparam logic [7:0] SSA_OFF_STATUS = 8'h08;
  localparam logic [7:0] SSA_OFF_RES1 = 8'h10;
  localparam logic [7:0] SSA_OFF_RES2 = 8'h14;
  localparam logic [7:0] SSA_OFF_RES3 = 8'h18;
  localparam logic [7:0] SSA_OFF_RESAUX = 8'h1c;
  // mode_control_reg field positions
  localparam int SSA_MUX_LO_BIT = 0;
  localparam int SSA_MUX_HI_BIT = 1;
  localparam int SSA_RATE_BIT = 7;
  localparam int SSA_MODE_W = 8;
  localparam int SSA_TRIM_W = 3;
  localparam int SSA_CNT_W = 12;
  localparam int SSA_NCH = 4;
  localparam logic [SSA_MODE_W-1:0] SSA_MODE_RST = 8'h00;
  localparam logic [SSA_TRIM_W-1:0] SSA_TRIM_RST = 3'h0;
  localparam logic [SSA_CNT_W-1:0] SSA_CNT_MAX = 12'hfff;
  localparam logic [SSA_CNT_W-1:0] SSA_NO_CONV = 12'h000;
  // aux selector codes
  localparam logic [1:0] SSA_SEL_AUX0 = 2'h0;
  localparam logic [1:0] SSA_SEL_AUX1 = 2'h1;
  localparam logic [1:0] SSA_SEL_AUX2 = 2'h2;
  localparam logic [1:0] SSA_SEL_VREF = 2'h3;

  typedef struct packed {
    logic [SSA_CNT_W-1:0] count;
    logic [SSA_NCH-1:0] trip;
  } ssa_capture_t;

  typedef enum logic {SSA_RESET_RAMP, SSA_RAMP} ssa_state_t;
endpackage

// ===== ssa_ramp_model.sv
// ramp and comparator model for the converter's analog side
`timescale 1ns/1ps
`default_nettype none
module ssa_ramp_model (
  // clock and ramp control
  input wire logic pclk,
  input wire logic ramp_discharge,
  // trip times in clocks: ch1..ch3, then aux inputs 0..3
  input wire logic [15:0] thr [7],
  // comparator levels
  output logic [2:0] comp_trip,
  output logic [3:0] comp_aux_in
);
  logic [15:0] ramp_q;
  always_ff @(posedge pclk) begin
    ramp_q <= ramp_discharge ? 16'h0 : ramp_q + 16'h1;
  end
  // a comparator stays tripped until the ramp is discharged
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      comp_trip[i] = !ramp_discharge && ramp_q >= thr[i];
    end
    for (int i = 0; i < 4; i++) begin
      comp_aux_in[i] = !ramp_discharge && ramp_q >= thr[i+3];
    end
  end
endmodule // ssa_ramp_model
`default_nettype wire

// ===== ssa_result_mem.sv
// per-channel result store with registered read port
`timescale 1ns/1ps
`default_nettype none
module ssa_result_mem
  import ssa_pkg::*;
#(
  parameter int NCH = SSA_NCH,
  parameter int W = SSA_CNT_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side, one enable per channel
  input wire logic [NCH-1:0] wr_en,
  input wire logic [W-1:0] wr_data [NCH],
  // read side
  input wire logic [1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [NCH];

  // each word holds until its channel writes again
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[g] <= '0;
        end else if (wr_en[g]) begin
          mem_q[g] <= wr_data[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule // ssa_result_mem
`default_nettype wire
